//--- hdl/eac_pkg.sv
//------------------------------------------------------------
// Function
//------------------------------------------------------------
package eac_pkg;

   //------------------------------------------------------------
   // Register map and fields
   //------------------------------------------------------------
   localparam logic [5:0] EAC_OFS_CTRL  = 6'h1F;
   localparam logic [5:0] EAC_OFS_DATA  = 6'h20;
   localparam logic [5:0] EAC_OFS_ADDRL = 6'h21;
   localparam logic [5:0] EAC_OFS_ADDRH = 6'h22;

   localparam int EAC_BIT_RE  = 0;
   localparam int EAC_BIT_WE  = 1;
   localparam int EAC_BIT_MWE = 2;
   localparam int EAC_BIT_RIE = 3;
   localparam int EAC_BIT_PM  = 4;

   localparam logic [1:0] EAC_PM_ATOMIC = 2'h0;
   localparam logic [1:0] EAC_PM_ERASE  = 2'h1;
   localparam logic [1:0] EAC_PM_WRITE  = 2'h2;
   localparam logic [7:0] EAC_ERASED    = 8'hFF;

   localparam logic [8:0] EAC_ADDR_RST = 9'h000;
   localparam logic [7:0] EAC_DATA_RST = 8'h00;
   localparam logic [1:0] EAC_PM_RST   = 2'h0;

   //------------------------------------------------------------
   // Timing
   //------------------------------------------------------------
   localparam logic [2:0] EAC_RD_STALL   = 3'h4;
   localparam logic [2:0] EAC_WR_STALL   = 3'h2;
   localparam logic [2:0] EAC_MWE_WINDOW = 3'h4;
   localparam int EAC_T_ATOMIC_US  = 3400;
   localparam int EAC_T_SPLIT_US   = 1800;
   localparam int EAC_TICKS_ATOMIC = 26368;
   localparam int EAC_TICKS_SPLIT  =
      EAC_TICKS_ATOMIC * EAC_T_SPLIT_US / EAC_T_ATOMIC_US;

   //------------------------------------------------------------
   // Types
   //------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } eac_io_req_t;

   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] data;
      logic [1:0] mode;
   } eac_job_t;

   typedef enum logic {EAC_IDLE, EAC_PROG} eac_state_t;

endpackage : eac_pkg

//--- hdl/eac_ctrl.sv
`timescale 1ns/10ps
module eac_ctrl #(
   parameter int TICKS_ATOMIC = eac_pkg::EAC_TICKS_ATOMIC,
   parameter int TICKS_SPLIT  = eac_pkg::EAC_TICKS_SPLIT
) (
   // Clock and resets
   input  wire logic               mclk,
   input  wire logic               reset_n,
   input  wire logic               por_n,
   // I/O space access
   input  wire eac_pkg::eac_io_req_t io_req,
   output      logic [7:0]         io_rdata_r,
   // CPU side
   input  wire logic               global_irq_en,
   input  wire logic               flash_selfprog_busy,
   output      logic               cpu_stall_r,
   output      logic               ready_irq_r,
   // Timing oscillator pin
   input  wire logic               rc_osc
);
   import eac_pkg::*;

   //------------------------------------------------------------
   // Storage and state
   //------------------------------------------------------------
   logic [7:0]  mem [0:511];
   logic [8:0]  address_reg_r;
   logic [7:0]  data_reg_r;
   logic        ready_irq_enable_r;
   logic        master_write_enable_r;
   logic [2:0]  mwe_cnt_r;
   logic [2:0]  stall_cnt_r;
   logic [1:0]  prog_mode_r;
   eac_state_t  state_r;
   eac_job_t    job_r;
   logic [14:0] tick_cnt_r;
   logic        rc_s1_r, rc_s2_r, rc_s3_r;
   logic        rst_s1_r, rst_s2_r;

   logic busy;
   logic wr_ctrl, wr_data, wr_addrl, wr_addrh;
   logic rd_trig, wr_trig, rc_tick;
   logic [14:0] tick_last;

   assign busy     = (state_r == EAC_PROG);
   assign wr_ctrl  = io_req.wr && (io_req.addr == EAC_OFS_CTRL);
   assign wr_data  = io_req.wr && (io_req.addr == EAC_OFS_DATA);
   assign wr_addrl = io_req.wr && (io_req.addr == EAC_OFS_ADDRL);
   assign wr_addrh = io_req.wr && (io_req.addr == EAC_OFS_ADDRH);
   assign rd_trig  = wr_ctrl && io_req.wdata[EAC_BIT_RE] && !busy;
   assign wr_trig  = wr_ctrl && io_req.wdata[EAC_BIT_WE] && !busy
                     && master_write_enable_r
                     && !flash_selfprog_busy;
   assign rc_tick  = rc_s2_r && !rc_s3_r;
   assign tick_last = (job_r.mode == EAC_PM_ATOMIC)
                      ? 15'(TICKS_ATOMIC - 1) : 15'(TICKS_SPLIT - 1);

   //------------------------------------------------------------
   // Synchronisers
   //------------------------------------------------------------
   // Engine side is held only by power-on so a write survives reset
   always_ff @(posedge mclk or negedge por_n) begin
      if (!por_n) begin
         rc_s1_r  <= 1'b0;
         rc_s2_r  <= 1'b0;
         rc_s3_r  <= 1'b0;
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rc_s1_r  <= rc_osc;
         rc_s2_r  <= rc_s1_r;
         rc_s3_r  <= rc_s2_r;
         rst_s1_r <= reset_n;
         rst_s2_r <= rst_s1_r;
      end
   end

   //------------------------------------------------------------
   // Address and data registers
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         address_reg_r <= EAC_ADDR_RST;
      end else if (!busy) begin
         if (wr_addrl) begin
            address_reg_r[7:0] <= io_req.wdata;
         end
         if (wr_addrh) begin
            address_reg_r[8] <= io_req.wdata[0];
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         data_reg_r <= EAC_DATA_RST;
      end else if (rd_trig) begin
         data_reg_r <= mem[address_reg_r];
      end else if (wr_data) begin
         data_reg_r <= io_req.wdata;
      end
   end

   //------------------------------------------------------------
   // Control bits
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ready_irq_enable_r <= 1'b0;
      end else if (wr_ctrl) begin
         ready_irq_enable_r <= io_req.wdata[EAC_BIT_RIE];
      end
   end

   // Re-setting inside the window does not stretch it
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         master_write_enable_r <= 1'b0;
         mwe_cnt_r             <= 3'h0;
      end else if (!master_write_enable_r) begin
         if (wr_ctrl && io_req.wdata[EAC_BIT_MWE]) begin
            master_write_enable_r <= 1'b1;
            mwe_cnt_r             <= EAC_MWE_WINDOW - 3'h1;
         end
      end else if (mwe_cnt_r == 3'h0) begin
         master_write_enable_r <= 1'b0;
      end else begin
         mwe_cnt_r <= mwe_cnt_r - 3'h1;
      end
   end

   //------------------------------------------------------------
   // CPU stall
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stall_cnt_r <= 3'h0;
         cpu_stall_r <= 1'b0;
      end else if (rd_trig) begin
         stall_cnt_r <= EAC_RD_STALL;
         cpu_stall_r <= 1'b1;
      end else if (wr_trig) begin
         stall_cnt_r <= EAC_WR_STALL;
         cpu_stall_r <= 1'b1;
      end else begin
         if (stall_cnt_r != 3'h0) begin
            stall_cnt_r <= stall_cnt_r - 3'h1;
         end
         cpu_stall_r <= (stall_cnt_r > 3'h1);
      end
   end

   //------------------------------------------------------------
   // Programming mode and write engine
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge por_n) begin
      if (!por_n) begin
         prog_mode_r <= EAC_PM_RST;
      end else if (!busy) begin
         if (!rst_s2_r) begin
            prog_mode_r <= EAC_PM_RST;
         end else if (wr_ctrl) begin
            prog_mode_r <= io_req.wdata[EAC_BIT_PM +: 2];
         end
      end
   end

   // Job is latched at start so later register writes cannot corrupt it
   always_ff @(posedge mclk or negedge por_n) begin
      if (!por_n) begin
         state_r    <= EAC_IDLE;
         job_r      <= '0;
         tick_cnt_r <= 15'h0000;
      end else begin
         case (state_r)
            EAC_IDLE: begin
               if (wr_trig && rst_s2_r) begin
                  state_r    <= EAC_PROG;
                  tick_cnt_r <= 15'h0000;
                  job_r      <= '{address_reg_r, data_reg_r, prog_mode_r};
               end
            end
            EAC_PROG: begin
               if (rc_tick) begin
                  if (tick_cnt_r == tick_last) begin
                     state_r <= EAC_IDLE;
                  end else begin
                     tick_cnt_r <= tick_cnt_r + 15'h0001;
                  end
               end
            end
            default: state_r <= EAC_IDLE;
         endcase
      end
   end

   // Nonvolatile cells: no reset by design
   always_ff @(posedge mclk) begin
      if (busy && rc_tick && (tick_cnt_r == tick_last)) begin
         case (job_r.mode)
            EAC_PM_ATOMIC: mem[job_r.addr] <= job_r.data;
            EAC_PM_ERASE:  mem[job_r.addr] <= EAC_ERASED;
            EAC_PM_WRITE:  mem[job_r.addr] <= mem[job_r.addr] & job_r.data;
            default:       mem[job_r.addr] <= mem[job_r.addr];
         endcase
      end
   end

   //------------------------------------------------------------
   // Interrupt and read-back
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ready_irq_r <= 1'b0;
      end else begin
         ready_irq_r <= ready_irq_enable_r && global_irq_en
                        && !busy && !flash_selfprog_busy;
      end
   end

   // Read strobe never stored, so it always reads back as zero
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         io_rdata_r <= 8'h00;
      end else if (io_req.rd) begin
         case (io_req.addr)
            EAC_OFS_CTRL:  io_rdata_r <= {2'b00, prog_mode_r,
                              ready_irq_enable_r, master_write_enable_r,
                              busy, 1'b0};
            EAC_OFS_DATA:  io_rdata_r <= data_reg_r;
            EAC_OFS_ADDRL: io_rdata_r <= address_reg_r[7:0];
            EAC_OFS_ADDRH: io_rdata_r <= {7'h00, address_reg_r[8]};
            default:       io_rdata_r <= 8'h00;
         endcase
      end
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   sequence stall_4_s;
      cpu_stall_r [*4] ##1 !cpu_stall_r;
   endsequence

   sequence stall_2_s;
      cpu_stall_r [*2] ##1 !cpu_stall_r;
   endsequence

   rd_stall_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rd_trig |=> stall_4_s)
      else $error("read stall length wrong");

   wr_stall_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (wr_trig && !rd_trig) |=> stall_2_s)
      else $error("write stall length wrong");

   mwe_timeout_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $rose(master_write_enable_r) |-> master_write_enable_r [*4]
         ##1 !master_write_enable_r)
      else $error("master enable window not four cycles");

   mode_lock_a: assert property (@(posedge mclk) disable iff (!por_n)
      (busy && $past(busy)) |-> $stable(prog_mode_r))
      else $error("mode changed during write");

   addr_lock_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      (busy && $past(busy)) |-> $stable(address_reg_r))
      else $error("address changed during write");

   no_unlock_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      (!busy && wr_ctrl && io_req.wdata[EAC_BIT_WE]
         && !master_write_enable_r) |=> !busy)
      else $error("write started without unlock");

   flash_block_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      (!busy && flash_selfprog_busy) |=> !busy)
      else $error("write started during flash programming");

   irq_quiet_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      (busy || flash_selfprog_busy) |=> !ready_irq_r)
      else $error("ready interrupt while busy");

   irq_level_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      (ready_irq_enable_r && global_irq_en && !busy
         && !flash_selfprog_busy) |=> ready_irq_r)
      else $error("ready interrupt missing");

   rd_data_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      rd_trig |=> (data_reg_r == mem[$past(address_reg_r)]))
      else $error("read data not loaded");

endmodule : eac_ctrl

//--- sim/eac_osc_model.sv
`timescale 1ns/10ps
module eac_osc_model #(
   parameter realtime HALF_NS = 43.0
) (
   // Oscillator pin
   output logic rc_osc
);
   // Free running, phase unrelated to mclk on purpose
   initial begin
      rc_osc = 1'b0;
      #7;
      forever #(HALF_NS) rc_osc = ~rc_osc;
   end
endmodule : eac_osc_model

//--- sim/eeprom_access_controller_test.sv
`timescale 1ns/10ps
module eeprom_access_controller_test;
   import eac_pkg::*;
   logic        mclk;
   logic        reset_n;
   logic        por_n;
   eac_io_req_t io_req;
   logic [7:0]  io_rdata_r;
   logic        global_irq_en;
   logic        flash_selfprog_busy;
   logic        cpu_stall_r;
   logic        ready_irq_r;
   logic        rc_osc;
   logic [7:0]  rv;
   int          n_errors;
   int          n_checks;
   int          nst;

   // Short write times keep the run brief
   eac_ctrl #(.TICKS_ATOMIC(8), .TICKS_SPLIT(4)) dut_u (
      .mclk(mclk), .reset_n(reset_n), .por_n(por_n), .io_req(io_req),
      .io_rdata_r(io_rdata_r), .global_irq_en(global_irq_en),
      .flash_selfprog_busy(flash_selfprog_busy),
      .cpu_stall_r(cpu_stall_r), .ready_irq_r(ready_irq_r),
      .rc_osc(rc_osc));
   eac_osc_model osc_u (.rc_osc(rc_osc));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // One request, held across its taking edge
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [7:0] d);
      @(posedge mclk);
      #1 io_req = '{wr: w, rd: ~w, addr: a, wdata: d};
      @(posedge mclk);
      #1 io_req = '0;
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [5:0] a);
      bus(1'b0, a, 8'h00);
      @(posedge mclk);
      #1 rv = io_rdata_r;
   endtask : rd

   task automatic cnt_stall;
      nst = 0;
      repeat (8) begin
         if (cpu_stall_r === 1'b1) nst++;
         @(posedge mclk);
         #1;
      end
   endtask : cnt_stall

   task automatic wait_idle;
      int k;
      for (k = 0; k < 300; k++) begin
         rd(EAC_OFS_CTRL);
         if (rv[1] === 1'b0) break;
      end
      chk(rv & 8'h02, 8'h00);
   endtask : wait_idle

   task automatic rst_pulse;
      reset_n = 1'b0;
      repeat (3) @(posedge mclk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
   endtask : rst_pulse

   // Unlock then strobe; gap pushes the strobe past the window
   task automatic prog(input logic [8:0] a, input logic [7:0] d,
                       input logic [7:0] m, input logic s, input int gap);
      logic g;
      g = global_irq_en;
      wr(EAC_OFS_ADDRL, a[7:0]);
      wr(EAC_OFS_ADDRH, {7'h00, a[8]});
      wr(EAC_OFS_DATA, d);
      global_irq_en = 1'b0;
      wr(EAC_OFS_CTRL, m | 8'h04);
      repeat (gap) @(posedge mclk);
      wr(EAC_OFS_CTRL, m | 8'h06);
      global_irq_en = g;
      cnt_stall();
      chk(8'(nst), s ? 8'h02 : 8'h00);
      rd(EAC_OFS_CTRL);
      chk({7'h00, rv[1]}, {7'h00, s});
   endtask : prog

   task automatic rd_mem(input logic [8:0] a, input logic [7:0] e);
      wr(EAC_OFS_ADDRL, a[7:0]);
      wr(EAC_OFS_ADDRH, {7'h00, a[8]});
      wr(EAC_OFS_CTRL, 8'h01);
      cnt_stall();
      chk(8'(nst), 8'h04);
      rd(EAC_OFS_DATA);
      chk(rv, e);
      rd(EAC_OFS_CTRL);
      chk(rv & 8'h01, 8'h00);
   endtask : rd_mem

   //------------------------------------------------------------
   // Tests
   //------------------------------------------------------------
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end

   initial begin
      io_req = '0;
      reset_n = 1'b0;
      por_n = 1'b0;
      global_irq_en = 1'b0;
      flash_selfprog_busy = 1'b0;
      n_errors = 0;
      n_checks = 0;
      repeat (12) @(posedge mclk);
      #1 por_n = 1'b1;
      reset_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      rd(EAC_OFS_CTRL);
      chk(rv, 8'h00);
      rd(EAC_OFS_ADDRH);
      chk(rv, 8'h00);
      rd(6'h30);
      chk(rv, 8'h00);
      global_irq_en = 1'b1;
      prog(9'h000, 8'h33, 8'h08, 1'b1, 0);
      chk({7'h00, ready_irq_r}, 8'h00);
      wait_idle();
      repeat (2) @(posedge mclk);
      #1 chk({7'h00, ready_irq_r}, 8'h01);
      global_irq_en = 1'b0;
      repeat (2) @(posedge mclk);
      #1 chk({7'h00, ready_irq_r}, 8'h00);
      global_irq_en = 1'b1;
      prog(9'h1FF, 8'hC6, 8'h08, 1'b1, 0);
      wait_idle();
      rd_mem(9'h000, 8'h33);
      rd_mem(9'h1FF, 8'hC6);
      // Mode, address and read-strobe writes landing while busy must bounce; the RIE bit still lands
      prog(9'h0A5, 8'h5A, 8'h08, 1'b1, 0);
      wr(EAC_OFS_CTRL, 8'h28);
      wr(EAC_OFS_ADDRL, 8'h11);
      rd(EAC_OFS_CTRL);
      chk(rv & 8'hF2, 8'h02);
      wr(EAC_OFS_CTRL, 8'h01);
      cnt_stall();
      chk(8'(nst), 8'h00);
      rd(EAC_OFS_ADDRL);
      chk(rv, 8'hA5);
      wait_idle();
      rd_mem(9'h0A5, 8'h5A);
      prog(9'h0A5, 8'h0F, 8'h28, 1'b1, 0);
      wait_idle();
      rd_mem(9'h0A5, 8'h0A);
      prog(9'h0A5, 8'h00, 8'h18, 1'b1, 0);
      wait_idle();
      rd_mem(9'h0A5, 8'hFF);
      prog(9'h0A5, 8'h00, 8'h38, 1'b1, 0);
      wait_idle();
      rd_mem(9'h0A5, 8'hFF);
      // Unlock rules
      wr(EAC_OFS_CTRL, 8'h0C);
      rd(EAC_OFS_CTRL);
      chk(rv & 8'h04, 8'h04);
      repeat (4) @(posedge mclk);
      rd(EAC_OFS_CTRL);
      chk(rv & 8'h04, 8'h00);
      wr(EAC_OFS_CTRL, 8'h0A);
      cnt_stall();
      chk(8'(nst), 8'h00);
      rd(EAC_OFS_CTRL);
      chk(rv & 8'h02, 8'h00);
      prog(9'h0A5, 8'h12, 8'h08, 1'b0, 4);
      // Flash self-programming blocks both start and interrupt
      flash_selfprog_busy = 1'b1;
      prog(9'h0A5, 8'h12, 8'h08, 1'b0, 0);
      chk({7'h00, ready_irq_r}, 8'h00);
      flash_selfprog_busy = 1'b0;
      rd_mem(9'h0A5, 8'hFF);
      // Reset in mid-write, then reset while idle
      prog(9'h0A5, 8'h3C, 8'h28, 1'b1, 0);
      rst_pulse();
      rd(EAC_OFS_CTRL);
      chk(rv & 8'h32, 8'h22);
      wait_idle();
      rd_mem(9'h0A5, 8'h3C);
      wr(EAC_OFS_CTRL, 8'h20);
      rst_pulse();
      rd(EAC_OFS_CTRL);
      chk(rv, 8'h00);
      rd(EAC_OFS_ADDRL);
      chk(rv, 8'h00);
      stop_test();
   end
endmodule : eeprom_access_controller_test
